// File: dv/cpu_clock_source_switch_tb.sv
// Self-checking bench for the CPU clock source switch
`timescale 1ns/1ps
module cpu_clock_source_switch_tb;
  import clock_switch_pkg::*;
  localparam int          SLOW_HALF = 8;
  localparam int          FAST_HALF = 3;
  localparam logic [15:0] HOLE_ADDR = 16'hFF08;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_crystal_osc = 1'b0;
  logic        fast_ceramic_osc = 1'b0;
  logic        fast_osc_enable;
  logic        cpu_sys_clk;
  logic        cpu_on_fast;
  logic [31:0] rdat;
  logic        rerr;
  logic        armed;
  logic        last_clk;
  int          fail_count;
  int          samples_checked;
  int          run;
  int          last_run;
  int          sc = 0;
  int          fc = 0;

  cpu_clock_source_switch dut_u
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .slow_crystal_osc (slow_crystal_osc),
    .fast_ceramic_osc (fast_ceramic_osc),
    .fast_osc_enable  (fast_osc_enable),
    .cpu_sys_clk      (cpu_sys_clk),
    .cpu_on_fast      (cpu_on_fast)
  );

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // A stopped resonator sits low; the model settles at once, far sooner than a real one
  always @(posedge pclk)
  begin
    sc <= (sc == SLOW_HALF - 1) ? 0 : sc + 1;
    if (sc == SLOW_HALF - 1)
      slow_crystal_osc <= ~slow_crystal_osc;
    fc <= (fast_osc_enable !== 1'b1 || fc == FAST_HALF - 1) ? 0 : fc + 1;
    if (fast_osc_enable !== 1'b1)
      fast_ceramic_osc <= 1'b0;
    else if (fc == FAST_HALF - 1)
      fast_ceramic_osc <= ~fast_ceramic_osc;
  end

  // Phase lengths of the CPU clock; the first run after reset is partial, so skip it
  always @(posedge pclk)
  begin
    if (presetn !== 1'b1)
    begin
      armed <= 1'b0;
      run <= 0;
      last_clk <= cpu_sys_clk;
    end
    else if (cpu_sys_clk !== last_clk)
    begin
      if (armed)
      begin
        check(32'(run >= FAST_HALF), 32'h1);
        last_run <= run;
      end
      armed <= 1'b1;
      run <= 1;
      last_clk <= cpu_sys_clk;
    end
    else
      run <= run + 1;
  end

  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      check(32'(pready), 32'h1);
      close_out();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(rdat, exp);
  endtask

  // Switching waits for the old source to be low and then for the new one to fall, so allow a few slow periods
  task automatic wait_on(input logic v);
    int n;
    n = 0;
    while (cpu_on_fast !== v && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    check(32'(cpu_on_fast), 32'(v));
    if (n >= 200)
      close_out();
  endtask

  task automatic t_reset_values();
    rd_chk(CTRL_ADDR, 32'h0);
    check(32'(fast_osc_enable), 32'h0);
    check(32'(cpu_on_fast), 32'h0);
  endtask

  task automatic t_to_fast();
    wr(CTRL_ADDR, 32'h0000_0005);
    // Register outputs settle only after the edge that takes the write
    @(posedge pclk);
    check(32'(fast_osc_enable), 32'h1);
    repeat (20) @(posedge pclk);
    wr(CTRL_ADDR, 32'h0000_000F);
    rd_chk(CTRL_ADDR, 32'h0000_000D);
    wait_on(1'b1);
    repeat (40) @(posedge pclk);
    rd_chk(STATUS_ADDR, 32'h0000_0001);
    check(32'(last_run), 32'(FAST_HALF));
  endtask

  task automatic t_to_slow();
    wr(CTRL_ADDR, 32'h0000_0005);
    wait_on(1'b0);
    wr(CTRL_ADDR, 32'h0000_0001);
    @(posedge pclk);
    check(32'(fast_osc_enable), 32'h0);
    repeat (40) @(posedge pclk);
    check(32'(last_run), 32'(SLOW_HALF));
  endtask

  task automatic t_ignored_select();
    wr(CTRL_ADDR, 32'h0000_0008);
    rd_chk(CTRL_ADDR, 32'h0);
    repeat (40) @(posedge pclk);
    check(32'(cpu_on_fast), 32'h0);
  endtask

  task automatic t_voltage_gate();
    wr(CTRL_ADDR, 32'h0000_000C);
    rd_chk(CTRL_ADDR, 32'h0000_000C);
    repeat (40) @(posedge pclk);
    check(32'(cpu_on_fast), 32'h0);
    wr(CTRL_ADDR, 32'h0000_000D);
    wait_on(1'b1);
    wr(CTRL_ADDR, 32'h0000_0005);
    wait_on(1'b0);
    wr(CTRL_ADDR, 32'h0);
  endtask

  task automatic t_unmapped();
    wr(HOLE_ADDR, 32'h0000_000F);
    check(32'(rerr), 32'h1);
    rd_chk(HOLE_ADDR, 32'h0);
    check(32'(rerr), 32'h1);
    wr(STATUS_ADDR, 32'h0000_000F);
    check(32'(rerr), 32'h0);
    rd_chk(CTRL_ADDR, 32'h0);
  endtask

  task automatic t_mid_reset();
    wr(CTRL_ADDR, 32'h0000_000D);
    wait_on(1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(fast_osc_enable), 32'h0);
    check(32'(cpu_on_fast), 32'h0);
    presetn <= 1'b1;
    rd_chk(CTRL_ADDR, 32'h0);
  endtask

  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    last_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_to_fast();
    t_to_slow();
    t_ignored_select();
    t_voltage_gate();
    t_unmapped();
    t_mid_reset();
    close_out();
  end
endmodule

// File: hw/clock_glitch_free_mux.sv
// Glitch-free switch between two sampled oscillator clocks
`timescale 1ns/1ps
module clock_glitch_free_mux
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow_s,
  input  wire logic fast_s,
  input  wire logic want_fast,
  output logic      clk_out_q,
  output logic      on_fast_q,
  output logic      busy
);
  import clock_switch_pkg::*;

  mux_state_e state_q;
  mux_state_e state_d;
  logic       clk_out_d;
  logic       on_fast_d;
  logic       old_src;
  logic       new_src;
  logic [1:0] src_prev_q;
  logic [1:0] src_prev_d;
  logic       new_fell;

  always_comb
  begin
    old_src   = on_fast_q ? fast_s : slow_s;
    new_src   = want_fast ? fast_s : slow_s;
    src_prev_d = {fast_s, slow_s};
    // Only a fresh fall guarantees the new source a whole low phase
    new_fell  = !new_src && (want_fast ? src_prev_q[1] : src_prev_q[0]);
    state_d   = state_q;
    on_fast_d = on_fast_q;
    clk_out_d = old_src;
    case (state_q)
      MUX_FOLLOW:
      begin
        // Leave the old source only once it is low, so no high phase is cut
        if ((want_fast != on_fast_q) && !old_src)
        begin
          state_d = MUX_PARK; // RULE_13
        end
      end
      MUX_PARK:
      begin
        // Hold low until the new source falls; a late join would cut its low phase
        clk_out_d = 1'b0; // RULE_13
        if (new_fell) // RULE_13
        begin
          on_fast_d = want_fast;
          state_d   = MUX_FOLLOW;
        end
      end
      default:
      begin
        state_d = MUX_FOLLOW;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= MUX_FOLLOW;
      on_fast_q <= 1'b0;
      clk_out_q <= 1'b0;
      src_prev_q <= SYNC_RESET;
    end
    else
    begin
      state_q   <= state_d;
      on_fast_q <= on_fast_d;
      clk_out_q <= clk_out_d;
      src_prev_q <= src_prev_d;
    end
  end

  assign busy = (state_q == MUX_PARK) || (want_fast != on_fast_q);

  a_park_holds_low: assert property ( // RULE_13
    @(posedge pclk) disable iff (!presetn)
    (state_q == MUX_PARK) |=> !clk_out_q)
    else $error("clock output high while parked");

  a_src_stable_high: assert property ( // RULE_13
    @(posedge pclk) disable iff (!presetn)
    clk_out_q && $past(clk_out_q) |-> on_fast_q == $past(on_fast_q))
    else $error("clock source changed during a high phase");
endmodule

// File: hw/cpu_clock_source_switch.sv
// CPU clock source switch: control register on APB and source selection
`timescale 1ns/1ps

// What this block and its software do
// RULE_01 - Select bit picks fast or slow clock
// RULE_02 - Enable bit starts and stops fast oscillator
// RULE_03 - Voltage bit stored, only gates clock select
// RULE_04 - Select write ignored with both bits clear
// RULE_05 - Voltage bit clear never moves to fast
// RULE_06 - Reset clears all three control bits
// RULE_07 - Bit one has no storage, reads zero
// RULE_08 - Software waits five msec before selecting fast; the bench waits only about 1 us (20 pclk cycles)
// RULE_09 - Software allows extra settling margin
// RULE_10 - Software stops oscillator in separate write
// RULE_11 - Software keeps fast oscillator off when idle
// RULE_12 - Software clears select before oscillator enable
// RULE_13 - Source change never shortens clock phases
module cpu_clock_source_switch
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_crystal_osc,
  input  wire logic        fast_ceramic_osc,
  output logic             fast_osc_enable,
  output logic             cpu_sys_clk,
  output logic             cpu_on_fast
);
  import clock_switch_pkg::*;

  function automatic reg_sel_e decode(input logic [15:0] addr);
    reg_sel_e r;
    if (addr == CTRL_ADDR)
    begin
      r = REG_CTRL;
    end
    else if (addr == STATUS_ADDR)
    begin
      r = REG_STATUS;
    end
    else
    begin
      r = REG_NONE;
    end
    return r;
  endfunction

  logic        cpu_clock_select_q;
  logic        cpu_clock_select_d;
  logic        fast_osc_enable_q;
  logic        fast_osc_enable_d;
  logic        voltage_switch_bit_q;
  logic        voltage_switch_bit_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        setup;
  logic        access;
  logic        ctrl_wr;
  logic        want_fast;
  logic        mux_busy;
  logic        clk_q;
  logic        fast_q;
  logic [1:0]  osc_s;
  reg_sel_e    sel_now;

  // Oscillators are asynchronous to pclk; sample them before any use
  osc_sync u_osc_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({fast_ceramic_osc, slow_crystal_osc}),
    .sync_out (osc_s)
  );

  always_comb
  begin
    sel_now = decode(paddr);
    setup   = psel && !penable;
    access  = psel && penable;
    ctrl_wr = access && pwrite && (sel_now == REG_CTRL);
  end

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access && (sel_now == REG_NONE);

  always_comb
  begin
    cpu_clock_select_d   = cpu_clock_select_q;
    fast_osc_enable_d    = fast_osc_enable_q;
    voltage_switch_bit_d = voltage_switch_bit_q;
    if (ctrl_wr)
    begin
      fast_osc_enable_d    = pwdata[OSC_EN_BIT]; // RULE_02
      voltage_switch_bit_d = pwdata[VSB_BIT]; // RULE_03
      // A select of 1 with both enables clear is dropped; old value kept
      if (!(pwdata[SEL_BIT] && !pwdata[VSB_BIT] && !pwdata[OSC_EN_BIT]))
      begin
        cpu_clock_select_d = pwdata[SEL_BIT]; // RULE_01
      end // RULE_04
    end
  end

  always_comb
  begin
    prdata_d = prdata_q;
    if (setup && !pwrite)
    begin
      prdata_d = 32'h0000_0000;
      if (sel_now == REG_CTRL)
      begin
        prdata_d[SEL_BIT]    = cpu_clock_select_q; // RULE_01
        prdata_d[OSC_EN_BIT] = fast_osc_enable_q; // RULE_02
        prdata_d[VSB_BIT]    = voltage_switch_bit_q; // RULE_03
        prdata_d[UNUSED_BIT] = 1'b0; // RULE_07
      end
      else if (sel_now == REG_STATUS)
      begin
        prdata_d[STAT_FAST_BIT] = fast_q;
        prdata_d[STAT_BUSY_BIT] = mux_busy;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_clock_select_q   <= SEL_RESET; // RULE_06
      fast_osc_enable_q    <= OSC_EN_RESET; // RULE_06
      voltage_switch_bit_q <= VSB_RESET; // RULE_06
      prdata_q             <= 32'h0000_0000;
    end
    else
    begin
      cpu_clock_select_q   <= cpu_clock_select_d;
      fast_osc_enable_q    <= fast_osc_enable_d;
      voltage_switch_bit_q <= voltage_switch_bit_d;
      prdata_q             <= prdata_d;
    end
  end

  // The voltage bit has no supply effect here; it only gates the select
  assign want_fast = cpu_clock_select_q && voltage_switch_bit_q; // RULE_05

  // Limitation: selecting fast with the oscillator stopped parks the clock
  clock_glitch_free_mux u_mux
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .slow_s    (osc_s[0]),
    .fast_s    (osc_s[1]),
    .want_fast (want_fast),
    .clk_out_q (clk_q),
    .on_fast_q (fast_q),
    .busy      (mux_busy)
  );

  assign prdata          = prdata_q;
  assign fast_osc_enable = fast_osc_enable_q; // RULE_02
  assign cpu_sys_clk     = clk_q; // RULE_13
  assign cpu_on_fast     = fast_q; // RULE_01

  a_select_stored: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr && pwdata[SEL_BIT] && pwdata[VSB_BIT] |=> cpu_clock_select_q)
    else $error("clock select write of 1 not stored");

  a_osc_follows_write: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr |=> fast_osc_enable == $past(pwdata[OSC_EN_BIT]))
    else $error("oscillator enable does not follow write");

  a_vsb_stored: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr ##1 !psel ##1 (setup && !pwrite && sel_now == REG_CTRL)
    |=> prdata[VSB_BIT] == $past(pwdata[VSB_BIT], 3))
    else $error("voltage switch bit does not read back");

  a_select_ignored: assert property ( // RULE_04
    @(posedge pclk) disable iff (!presetn)
    ctrl_wr && pwdata[SEL_BIT] && !pwdata[VSB_BIT] && !pwdata[OSC_EN_BIT]
    |=> cpu_clock_select_q == $past(cpu_clock_select_q))
    else $error("clock select write not ignored");

  a_no_fast_low_vsb: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    !voltage_switch_bit_q && !cpu_on_fast |=> !cpu_on_fast)
    else $error("moved to fast clock with voltage bit clear");

  a_reset_clears: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> !cpu_clock_select_q && !fast_osc_enable && !voltage_switch_bit_q)
    else $error("control bits not clear after reset");

  a_unused_reads_zero: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && sel_now == REG_CTRL |-> !prdata[UNUSED_BIT])
    else $error("unused control bit reads one");

  a_fast_needs_vsb: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    $rose(cpu_on_fast) |-> $past(want_fast))
    else $error("fast clock taken without gated select");

  a_slow_unselected: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    !cpu_clock_select_q && !cpu_on_fast |=> !cpu_on_fast)
    else $error("moved to fast clock with select bit clear");

  a_osc_write_only: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    !ctrl_wr |=> $stable(fast_osc_enable))
    else $error("oscillator enable changed without a control write");
endmodule

// File: hw/osc_sync.sv
// Two-stage synchroniser for the oscillator levels
`timescale 1ns/1ps
module osc_sync
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  import clock_switch_pkg::*;

  logic [1:0] meta_q;
  logic [1:0] meta_d;
  logic [1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= SYNC_RESET;
      sync_out <= SYNC_RESET;
    end
    else
    begin
      meta_q   <= meta_d;
      sync_out <= sync_d;
    end
  end
endmodule

// File: inc/clock_switch_pkg.sv
// Constants and types shared by the CPU clock source switch
package clock_switch_pkg;

  // Register byte addresses on the APB
  localparam logic [15:0] CTRL_ADDR   = 16'hFF00;
  localparam logic [15:0] STATUS_ADDR = 16'hFF04;

  // Field positions in the control register
  localparam int unsigned SEL_BIT    = 3;
  localparam int unsigned OSC_EN_BIT = 2;
  localparam int unsigned UNUSED_BIT = 1;
  localparam int unsigned VSB_BIT    = 0;

  // Field positions in the status register
  localparam int unsigned STAT_FAST_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;

  // Values after reset
  localparam logic       SEL_RESET    = 1'b0;
  localparam logic       OSC_EN_RESET = 1'b0;
  localparam logic       VSB_RESET    = 1'b0;
  localparam logic [1:0] SYNC_RESET   = 2'h0;

  typedef enum logic [1:0] {
    REG_CTRL,
    REG_STATUS,
    REG_NONE
  } reg_sel_e;

  typedef enum logic {
    MUX_FOLLOW,
    MUX_PARK
  } mux_state_e;

endpackage
